// >>> verif/cms_seq_asserts.sv
/*
  cms_seq_asserts: port-level checks on cms_sequencer, bound in below.
  assumes the top's single clock and its async active-low reset.
*/
`timescale 1ns/1ps
module cms_seq_asserts
  import cms_pkg::*;
(
  input wire logic ref_clk_in, // clock
  input wire logic reset_n_in, // reset, active low
  input wire logic reconfig_n_in, // reconfig request
  input wire logic chain_enable_in_n, // chain enable in
  input wire cms_pkg::cms_scheme_t scheme_in, // scheme
  input wire logic par_valid_in, // parallel strobe
  input wire logic scan_valid_in, // scan strobe
  input wire logic array_ready_in, // array ready
  input wire logic src_ready_out, // source ready
  input wire cms_pkg::cms_word_t array_word_out, // array word
  input wire logic array_valid_out, // array valid
  input wire logic chain_enable_out_n, // chain out
  input wire cms_pkg::cms_io_ctrl_t io_ctrl_out, // io control
  input wire logic user_reset_out, // user reset
  input wire logic user_mode_out // user mode
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  // pins driven for eight cycles of init before user mode
  sequence s_init_run;
    !user_mode_out [*8] ##1 user_mode_out;
  endsequence
  // a byte of the fast parallel or boundary-scan scheme taken on this edge
  sequence s_byte_taken;
    src_ready_out && ((par_valid_in && scheme_in == CMS_SCHEME_FAST_PASSIVE_PARALLEL)
      || (scan_valid_in && scheme_in == CMS_SCHEME_BOUNDARY_SCAN));
  endsequence
  property p_mode_pair; user_mode_out != user_reset_out; endproperty
  property p_user_io; user_mode_out |-> io_ctrl_out == 2'h2; endproperty
  property p_pullup; !io_ctrl_out.drive_en |-> io_ctrl_out.weak_pullup; endproperty
  property p_no_load; src_ready_out |-> !user_mode_out && !io_ctrl_out.drive_en; endproperty
  property p_reconfig;
    !reconfig_n_in |-> ##2 !user_mode_out && !io_ctrl_out.drive_en;
  endproperty
  property p_chain_hold; chain_enable_in_n && !src_ready_out |=> !src_ready_out; endproperty
  property p_ready_gap; s_byte_taken |=> !src_ready_out; endproperty
  property p_word_hold;
    array_valid_out && !array_ready_in |=> array_valid_out && $stable(array_word_out);
  endproperty
  property p_chain_out; user_mode_out |-> !chain_enable_out_n; endproperty
  property p_init_len; $rose(io_ctrl_out.drive_en) |-> s_init_run; endproperty
  a_mode_pair: assert property (p_mode_pair) else $error("mode pair");
  a_user_io: assert property (p_user_io) else $error("user io");
  a_pullup: assert property (p_pullup) else $error("pullup");
  a_no_load: assert property (p_no_load) else $error("load in user");
  a_reconfig: assert property (p_reconfig) else $error("reconfig");
  a_chain_hold: assert property (p_chain_hold) else $error("chain hold");
  a_ready_gap: assert property (p_ready_gap) else $error("ready gap");
  a_word_hold: assert property (p_word_hold) else $error("word hold");
  a_chain_out: assert property (p_chain_out) else $error("chain out");
  a_init_len: assert property (p_init_len) else $error("init len");
endmodule

bind cms_sequencer cms_seq_asserts i_chk (.ref_clk_in, .reset_n_in, .reconfig_n_in,
  .chain_enable_in_n, .scheme_in, .par_valid_in, .scan_valid_in, .array_ready_in,
  .src_ready_out, .array_word_out, .array_valid_out, .chain_enable_out_n, .io_ctrl_out,
  .user_reset_out, .user_mode_out);

// >>> verif/cms_src_model.sv
/*
  cms_src_model: configuration source, a memory or host sending an image
  byte-wide or bit-serial. assumes the sequencer's registered ready.
*/
`timescale 1ns/1ps
module cms_src_model #(
  parameter int NBYTES = 4
) (
  input wire logic ref_clk_in, // clock
  input wire logic go_in, // send from byte 0
  input wire logic serial_in, // bit per strobe, msb first
  input wire logic [7:0] gap_in, // idle cycles between bytes
  input wire logic ready_in, // sequencer ready
  output logic stb_out, // byte or bit strobe
  output logic [7:0] data_out, // byte, inverted when idle
  output logic bit_out // serial bit
);
  int idx = 0;
  int bitn = 0;
  int wt = 0;
  logic [7:0] cur;
  // idle lines never keep a stale value
  assign cur = 8'h81 + 8'h3C * idx[7:0];
  assign data_out = stb_out ? cur : ~cur;
  assign bit_out = stb_out ? cur[7 - bitn] : ~cur[7 - bitn];
  // strobe only after a seen ready; dropped when not taken, raised again later
  always @(posedge ref_clk_in) begin
    if (!go_in) begin
      stb_out <= 1'b0;
      idx <= 0;
      bitn <= 0;
      wt <= 0;
    end else if (stb_out && ready_in && serial_in && bitn < 7) begin
      bitn <= bitn + 1; // bits go back to back
    end else if (stb_out) begin
      stb_out <= 1'b0;
      if (ready_in) begin
        bitn <= 0;
        idx <= idx + 1;
        wt <= gap_in;
      end
    end else if (wt > 0) begin
      wt <= wt - 1;
    end else if (ready_in && idx < NBYTES) begin
      stb_out <= 1'b1;
    end
  end
endmodule

// >>> verif/test_cms_sequencer.sv
/*
  test_cms_sequencer: self-checking bench of cms_sequencer with a source model.
  assumes short image and load limit parameters for a brief run.
*/
`timescale 1ns/1ps
module test_cms_sequencer;
  import cms_pkg::*;
  localparam int NB = 4; // image bytes, shortened
  localparam int LIM = 80; // load limit cycles, shortened
  `define CHK(nm, ex, sn) begin tests_run++; if ((sn) !== (ex)) begin n_errors++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, sn); end end
  logic ref_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic reconfig_n_in = 1'b1;
  logic chain_n = 1'b1;
  logic go = 1'b0;
  logic arr_rdy = 1'b1;
  logic [7:0] gap = 8'h00;
  cms_scheme_t sch = CMS_SCHEME_FAST_PASSIVE_PARALLEL;
  logic src_rdy, stb, sbit, arr_vld, ch_out_n, u_rst, u_mode, l_err, ser;
  logic [7:0] bdat;
  cms_word_t word;
  cms_io_ctrl_t ioc;
  cms_word_t got[$];
  int n_errors = 0;
  int tests_run = 0;
  assign ser = sch == CMS_SCHEME_CFG_MEMORY || sch == CMS_SCHEME_PASSIVE_SERIAL;
  always #12.5 ref_clk_in = ~ref_clk_in;
  cms_src_model #(.NBYTES(NB)) i_src (.ref_clk_in(ref_clk_in), .go_in(go), .serial_in(ser),
    .gap_in(gap), .ready_in(src_rdy), .stb_out(stb), .data_out(bdat), .bit_out(sbit));
  cms_sequencer #(.IMAGE_BYTES(NB), .LOAD_LIMIT_CYCLES(LIM)) i_dut (.ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in), .reconfig_n_in(reconfig_n_in), .chain_enable_in_n(chain_n),
    .scheme_in(sch), .serial_valid_in(stb && ser), .serial_bit_in(sbit),
    .par_valid_in(stb && sch == CMS_SCHEME_FAST_PASSIVE_PARALLEL), .par_data_in(bdat),
    .host_wr_in(stb && sch == CMS_SCHEME_PASSIVE_PARALLEL_ASYNC), .host_data_in(bdat),
    .scan_valid_in(stb && sch == CMS_SCHEME_BOUNDARY_SCAN), .scan_data_in(bdat),
    .array_ready_in(arr_rdy), .src_ready_out(src_rdy), .array_word_out(word),
    .array_valid_out(arr_vld), .chain_enable_out_n(ch_out_n), .io_ctrl_out(ioc),
    .user_reset_out(u_rst), .user_mode_out(u_mode), .load_error_out(l_err));
  // words the cell array accepted
  always @(posedge ref_clk_in) if (arr_vld && arr_rdy) got.push_back(word);
  task automatic cyc(int n);
    repeat (n) @(posedge ref_clk_in);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // bounded wait; a hang ends the run at once
  task automatic wait_for(int lim, int nwords);
    for (int i = 0; i < lim && (nwords > 0 ? got.size() < nwords : u_mode !== 1'b1); i++)
      cyc(1);
    if (nwords > 0 ? got.size() < nwords : u_mode !== 1'b1) begin
      n_errors++;
      $display("CHECK FAILED wait expected done seen timeout");
      summarize();
    end
  endtask
  // pins float with pull-ups in reset; no load while the chain is disabled
  task automatic t_reset();
    cyc(5);
    `CHK("io_ctrl", 2'h1, ioc)
    `CHK("user_mode", 1'b0, u_mode)
    `CHK("chain_out_n", 1'b1, ch_out_n)
    cyc(15);
    reset_n_in <= 1'b1;
    cyc(40);
    `CHK("src_ready", 1'b0, src_rdy)
    `CHK("user_mode", 1'b0, u_mode)
  endtask
  // one full image; optional array stall at the start
  task automatic t_load(cms_scheme_t s, logic [7:0] g, int stall);
    sch <= s;
    gap <= g;
    got.delete();
    arr_rdy <= stall == 0;
    go <= 1'b1;
    chain_n <= 1'b0;
    cyc(stall);
    arr_rdy <= 1'b1;
    wait_for(3000, 0);
    `CHK("bytes", NB, got.size())
    for (int i = 0; i < got.size(); i++)
      `CHK("word", {8'(8'h81 + 8'h3C * i), i == NB - 1}, got[i])
    `CHK("io_ctrl", 2'h2, ioc)
    `CHK("user_reset", 1'b0, u_rst)
    `CHK("chain_out_n", 1'b0, ch_out_n)
    `CHK("load_error", g != 8'h00, l_err)
  endtask
  // reconfig pin pulls the device back into command mode
  task automatic t_reconf();
    go <= 1'b0;
    reconfig_n_in <= 1'b0;
    cyc(4);
    `CHK("user_mode", 1'b0, u_mode)
    `CHK("io_ctrl", 2'h1, ioc)
    reconfig_n_in <= 1'b1;
    chain_n <= 1'b1;
    cyc(2);
  endtask
  // reconfig mid-image: a partial image never starts init
  task automatic t_abort();
    got.delete();
    go <= 1'b1;
    chain_n <= 1'b0;
    wait_for(500, 2);
    `CHK("user_mode", 1'b0, u_mode)
    `CHK("last_flag", 1'b0, got[1].last)
    t_reconf();
  endtask
  // power-on reset from user mode leaves an unloaded device
  task automatic t_rst_mid();
    reset_n_in <= 1'b0;
    go <= 1'b0;
    cyc(2);
    `CHK("user_mode", 1'b0, u_mode)
    `CHK("io_ctrl", 2'h1, ioc)
    reset_n_in <= 1'b1;
    cyc(2);
    `CHK("src_ready", 1'b0, src_rdy)
  endtask
  initial begin
    t_reset();
    t_load(CMS_SCHEME_FAST_PASSIVE_PARALLEL, 8'h00, 20);
    for (int k = 0; k < 5; k++) begin
      t_reconf();
      t_load(cms_scheme_t'(k[2:0]), 8'h00, 0);
    end
    t_reconf();
    t_load(CMS_SCHEME_BOUNDARY_SCAN, 8'h1E, 0);
    // abort mid-image, then a fresh full load
    t_reconf();
    t_abort();
    t_load(CMS_SCHEME_FAST_PASSIVE_PARALLEL, 8'h00, 0);
    // reset again in user mode, then a load from a memory source
    t_rst_mid();
    t_load(CMS_SCHEME_CFG_MEMORY, 8'h00, 0);
    summarize();
  end
endmodule

// >>> verilog/cms_fifo.sv
/*
  cms_fifo: small flip-flop fifo with valid/ready on both sides.
  assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
module cms_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input wire logic ref_clk_in, // system clock
  input wire logic reset_n_in, // async reset, active low
  input wire logic flush_in, // drop all stored words
  input wire logic [WIDTH-1:0] wr_data_in, // write data
  input wire logic wr_valid_in, // write request
  output logic wr_ready_out, // room for a word
  output logic [WIDTH-1:0] rd_data_out, // oldest word
  output logic rd_valid_out, // a word is present
  input wire logic rd_ready_in // reader takes the word
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic push;
  logic pop;

  assign push = wr_valid_in && (count_ff != (AW+1)'(DEPTH)) && !flush_in;
  assign pop = rd_ready_in && (count_ff != '0) && !flush_in;
  assign wr_ready_out = (count_ff != (AW+1)'(DEPTH));
  assign rd_valid_out = (count_ff != '0);
  assign rd_data_out = mem_ff[rd_ptr_ff];

  // storage written only on push, no reset needed for data
  always_ff @(posedge ref_clk_in) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= wr_data_in;
    end
  end

  // pointers and fill level
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else if (flush_in) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + AW'(1);
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + AW'(1);
      end
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// >>> verilog/cms_pkg.sv
/*
  cms_pkg: shared types and constants for the configuration mode sequencer.
  assumes a single 40 MHz clock domain; all counts are in cycles of it.
*/
package cms_pkg;

  // configuration source schemes, selected by static mode straps
  typedef enum logic [2:0] {
    CMS_SCHEME_CFG_MEMORY,
    CMS_SCHEME_PASSIVE_SERIAL,
    CMS_SCHEME_PASSIVE_PARALLEL_ASYNC,
    CMS_SCHEME_FAST_PASSIVE_PARALLEL,
    CMS_SCHEME_BOUNDARY_SCAN
  } cms_scheme_t;

  // sequencer phases
  typedef enum logic [2:0] {
    CMS_ST_POWER_UP,
    CMS_ST_CLEAR,
    CMS_ST_WAIT_CHAIN,
    CMS_ST_LOAD,
    CMS_ST_INIT,
    CMS_ST_USER
  } cms_state_t;

  // one configuration write from any scheme
  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } cms_word_t;

  // pin control for the user i/o bank
  typedef struct packed {
    logic drive_en;
    logic weak_pullup;
  } cms_io_ctrl_t;

  localparam int CMS_DATA_W = 8;
  localparam int CMS_FIFO_DEPTH = 4;
  localparam int CMS_CLK_HZ = 40000000;
  // clear phase after power-up or reconfig request
  localparam int CMS_CLEAR_CYCLES = 16;
  // register reset length during initialization
  localparam int CMS_INIT_CYCLES = 8;
  // default image length in bytes; a parameter of the top
  localparam int CMS_IMAGE_BYTES = 1024;
  // load must finish within 100 ms at 100 MHz byte rate
  localparam int CMS_LOAD_LIMIT_MS = 100;
  localparam int CMS_LOAD_LIMIT_CYCLES = CMS_CLK_HZ / 1000 * CMS_LOAD_LIMIT_MS;
  localparam logic [2:0] CMS_SCHEME_COUNT = 3'h5;

endpackage

// >>> verilog/cms_sequencer.sv
/*
  cms_sequencer: moves the device from power-up through configuration
  load and initialization (command mode) into user mode, and back on a
  reconfiguration request. configuration writes arrive as bytes from
  any of five schemes through a 4-word fifo into the cell array.
  assumes all inputs synchronous to ref_clk_in; the array port is
  a simple valid/ready sink.
*/
// Overview of operation
// - after every reset the device must load a fresh image before running.
// - i/o pins stay undriven during power-up, waiting and loading.
// - after loading, initialization resets registers, enables i/o, starts logic.
// - loading plus initialization is command mode; afterwards is user mode.
// - user i/o pins are weakly pulled up before and during configuration; the code drops the pull-ups once initialization starts.
// - reconfig pin low forces command mode, new load, reinit, user mode.
// - chain enable output low passes configuration to the next device.
// - five schemes supply data: memory, serial, parallel async, fast, scan.
// - byte-wide 100 MHz data loads within 100 ms.
// - a host writes configuration bytes to one virtual memory location.
`timescale 1ns/1ps
module cms_sequencer
  import cms_pkg::*;
#(
  parameter int IMAGE_BYTES = cms_pkg::CMS_IMAGE_BYTES,
  parameter int LOAD_LIMIT_CYCLES = cms_pkg::CMS_LOAD_LIMIT_CYCLES
) (
  input wire logic ref_clk_in, // 40 MHz clock
  input wire logic reset_n_in, // power-on reset, async, active low
  input wire logic reconfig_n_in, // reconfiguration request, active low
  input wire logic chain_enable_in_n, // chain enable in, active low
  input wire cms_pkg::cms_scheme_t scheme_in, // selected scheme, static
  input wire logic serial_valid_in, // serial bit strobe
  input wire logic serial_bit_in, // serial data bit
  input wire logic par_valid_in, // parallel byte strobe (both parallel schemes)
  input wire logic [7:0] par_data_in, // parallel byte
  input wire logic host_wr_in, // host write to the virtual location
  input wire logic [7:0] host_data_in, // host write data
  input wire logic scan_valid_in, // boundary-scan byte strobe
  input wire logic [7:0] scan_data_in, // boundary-scan byte
  input wire logic array_ready_in, // cell array accepts a byte
  output logic src_ready_out, // source may send, registered
  output cms_pkg::cms_word_t array_word_out, // byte to cell array
  output logic array_valid_out, // array byte valid
  output logic chain_enable_out_n, // chain enable out, active low
  output cms_pkg::cms_io_ctrl_t io_ctrl_out, // user i/o control
  output logic user_reset_out, // holds user registers in reset
  output logic user_mode_out, // device runs as logic
  output logic load_error_out // load overran time limit
);
  import cms_pkg::*;

  localparam int BW = $clog2(IMAGE_BYTES + 1);
  localparam int TW = $clog2(LOAD_LIMIT_CYCLES + 1);

  cms_state_t state_ff;
  logic [4:0] phase_cnt_ff;
  logic [BW-1:0] byte_cnt_ff;
  logic [TW-1:0] load_tmr_ff;
  logic [7:0] shift_ff;
  logic [2:0] bit_cnt_ff;
  logic in_valid;
  logic [7:0] in_data;
  logic fifo_ready;
  logic fifo_flush;
  cms_word_t fifo_in;
  cms_word_t fifo_out;
  logic fifo_valid;
  logic fifo_pop;
  logic last_sent;
  logic serial_done;

  // serial bytes assemble msb first from passive serial or memory sources
  assign serial_done = serial_valid_in && (bit_cnt_ff == 3'h7);

  // scheme mux: only the selected scheme's strobe is heard
  always_comb begin
    in_valid = 1'b0;
    in_data = 8'h00;
    unique case (scheme_in)
      CMS_SCHEME_CFG_MEMORY, CMS_SCHEME_PASSIVE_SERIAL: begin
        in_valid = serial_done;
        in_data = {shift_ff[6:0], serial_bit_in};
      end
      CMS_SCHEME_PASSIVE_PARALLEL_ASYNC: begin
        in_valid = par_valid_in || host_wr_in;
        in_data = host_wr_in ? host_data_in : par_data_in;
      end
      CMS_SCHEME_FAST_PASSIVE_PARALLEL: begin
        in_valid = par_valid_in;
        in_data = par_data_in;
      end
      CMS_SCHEME_BOUNDARY_SCAN: begin
        in_valid = scan_valid_in;
        in_data = scan_data_in;
      end
      default: begin
        in_valid = 1'b0;
        in_data = 8'h00;
      end
    endcase
  end

  assign fifo_in.data = in_data;
  assign fifo_in.last = (byte_cnt_ff == BW'(IMAGE_BYTES - 1));
  assign fifo_flush = (state_ff != CMS_ST_LOAD);
  assign fifo_pop = fifo_valid && (!array_valid_out || array_ready_in);
  assign last_sent = array_valid_out && array_ready_in && array_word_out.last;

  // fifo soaks up bursts while the array stalls
  cms_fifo #(
    .WIDTH($bits(cms_word_t)),
    .DEPTH(CMS_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .flush_in(fifo_flush),
    .wr_data_in(fifo_in),
    .wr_valid_in(in_valid && src_ready_out),
    .wr_ready_out(fifo_ready),
    .rd_data_out(fifo_out),
    .rd_valid_out(fifo_valid),
    .rd_ready_in(fifo_pop)
  );

  // serial shifter; cleared outside load so a new image starts aligned
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      shift_ff <= 8'h00;
      bit_cnt_ff <= 3'h0;
    end else if (state_ff != CMS_ST_LOAD) begin
      shift_ff <= 8'h00;
      bit_cnt_ff <= 3'h0;
    end else if (serial_valid_in && src_ready_out) begin
      shift_ff <= {shift_ff[6:0], serial_bit_in};
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
    end
  end

  // source ready registered; dropped for a cycle after each byte to cover its lag
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      src_ready_out <= 1'b0;
    end else begin
      src_ready_out <= (state_ff == CMS_ST_LOAD) && fifo_ready && !in_valid
        && (byte_cnt_ff != BW'(IMAGE_BYTES));
    end
  end

  // array output stage
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      array_word_out <= '0;
      array_valid_out <= 1'b0;
    end else if (state_ff != CMS_ST_LOAD) begin
      array_valid_out <= 1'b0;
    end else if (fifo_pop) begin
      array_word_out <= fifo_out;
      array_valid_out <= 1'b1;
    end else if (array_ready_in) begin
      array_valid_out <= 1'b0;
    end
  end

  // byte count restarts every load
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      byte_cnt_ff <= '0;
    end else if (state_ff != CMS_ST_LOAD) begin
      byte_cnt_ff <= '0;
    end else if (in_valid && src_ready_out) begin
      byte_cnt_ff <= byte_cnt_ff + BW'(1);
    end
  end

  // load timer flags an overrun but keeps waiting for data
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      load_tmr_ff <= '0;
      load_error_out <= 1'b0;
    end else if (state_ff == CMS_ST_CLEAR) begin
      load_tmr_ff <= '0;
      load_error_out <= 1'b0;
    end else if (state_ff == CMS_ST_LOAD) begin
      if (load_tmr_ff == TW'(LOAD_LIMIT_CYCLES)) begin
        load_error_out <= 1'b1;
      end else begin
        load_tmr_ff <= load_tmr_ff + TW'(1);
      end
    end
  end

  // phase sequencing; reconfig request wins from any state
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_ff <= CMS_ST_POWER_UP;
      phase_cnt_ff <= '0;
    end else if (!reconfig_n_in) begin
      state_ff <= CMS_ST_CLEAR;
      phase_cnt_ff <= '0;
    end else begin
      unique case (state_ff)
        CMS_ST_POWER_UP: begin
          state_ff <= CMS_ST_CLEAR;
        end
        CMS_ST_CLEAR: begin
          phase_cnt_ff <= phase_cnt_ff + 5'h1;
          if (phase_cnt_ff == 5'(CMS_CLEAR_CYCLES - 1)) begin
            state_ff <= CMS_ST_WAIT_CHAIN;
            phase_cnt_ff <= '0;
          end
        end
        CMS_ST_WAIT_CHAIN: begin
          if (!chain_enable_in_n) begin
            state_ff <= CMS_ST_LOAD;
          end
        end
        CMS_ST_LOAD: begin
          if (last_sent) begin
            state_ff <= CMS_ST_INIT;
          end
        end
        CMS_ST_INIT: begin
          phase_cnt_ff <= phase_cnt_ff + 5'h1;
          if (phase_cnt_ff == 5'(CMS_INIT_CYCLES - 1)) begin
            state_ff <= CMS_ST_USER;
            phase_cnt_ff <= '0;
          end
        end
        CMS_ST_USER: begin
          state_ff <= CMS_ST_USER;
        end
      endcase
    end
  end

  // pin and mode outputs follow the phase one cycle later
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      io_ctrl_out.drive_en <= 1'b0;
      io_ctrl_out.weak_pullup <= 1'b1;
      user_reset_out <= 1'b1;
      user_mode_out <= 1'b0;
      chain_enable_out_n <= 1'b1;
    end else begin
      // drivers off until init releases them
      io_ctrl_out.drive_en <= (state_ff == CMS_ST_INIT) || (state_ff == CMS_ST_USER);
      // pull-ups only up to the end of loading
      io_ctrl_out.weak_pullup <= (state_ff != CMS_ST_INIT) && (state_ff != CMS_ST_USER);
      user_reset_out <= (state_ff != CMS_ST_USER);
      user_mode_out <= (state_ff == CMS_ST_USER);
      // hand the chain on once this device has its full image
      chain_enable_out_n <= !((state_ff == CMS_ST_INIT) || (state_ff == CMS_ST_USER));
    end
  end
endmodule
